// >>> core/pws_pkg.sv
package pws_pkg;

    // ******************************************
    // Window geometry and register offsets
    // ******************************************
    localparam int          WIN_BITS      = 12;          // 4 KB per window
    localparam logic [11:0] CFG_ID        = 12'h000;
    localparam logic [11:0] CFG_IF_BASE   = 12'h010;
    localparam logic [11:0] CFG_DEV_BASE  = 12'h014;
    localparam logic [11:0] IF_SETTING    = 12'h0c4;
    localparam logic [11:0] IF_FINALIZE   = 12'h0f4;
    localparam logic [11:0] IF_SETUP_KEY  = 12'h340;

    // ******************************************
    // Values, masks and reset values
    // ******************************************
    localparam logic [31:0] BAR_MASK      = 32'hfffff000;
    localparam logic [31:0] KEY_VALUE     = 32'h0000aeae;
    localparam logic [31:0] SET_EN_BITS   = 32'h0000008c;
    localparam logic [31:0] REG_RESET     = 32'h00000000;

    // ******************************************
    // Host request carrier
    // ******************************************
    typedef struct packed {
        logic        is_cfg;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } pws_req_t;

    typedef enum logic [1:0] {
        PWS_IDLE,
        PWS_FWD,
        PWS_RESP
    } pws_state_t;

    function automatic logic pws_in_window(input logic [31:0] addr, input logic [31:0] base);
        pws_in_window = ((addr & BAR_MASK) == (base & BAR_MASK));
    endfunction : pws_in_window

endpackage : pws_pkg

// >>> core/pws_window_setup.sv
`timescale 1ns/1ps

module pws_window_setup
    import pws_pkg::*;
#(
    parameter logic [15:0] VENDOR_CODE = 16'h0a5a,   // Arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'h0c3c,   // Arbitrary value
    parameter int          TRIG_LINES  = 7
) (
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    input  wire logic                  req_valid,
    input  wire pws_req_t              req,
    output logic                       req_ready,
    output logic                       resp_valid,
    output logic [31:0]                resp_rdata,
    output logic                       resp_miss,
    output logic                       cnt_req,
    output logic                       cnt_write,
    output logic [WIN_BITS-1:0]        cnt_addr,
    output logic [31:0]                cnt_wdata,
    input  wire logic                  cnt_ack,
    input  wire logic [31:0]           cnt_rdata,
    output logic                       dev_win_enabled,
    output logic                       setup_key_ok,
    input  wire logic [TRIG_LINES-1:0] chip0_trig_out,
    input  wire logic [TRIG_LINES-1:0] chip0_trig_oe,
    input  wire logic [TRIG_LINES-1:0] chip1_trig_out,
    input  wire logic [TRIG_LINES-1:0] chip1_trig_oe,
    output logic [TRIG_LINES-1:0]      chip0_trig_in,
    output logic [TRIG_LINES-1:0]      chip1_trig_in,
    input  wire logic [TRIG_LINES-1:0] trig_pin_i,
    output logic [TRIG_LINES-1:0]      trig_pin_o,
    output logic [TRIG_LINES-1:0]      trig_pin_oe,
    output logic                       trig_conflict
);

    // ******************************************
    // Registers
    // ******************************************
    pws_state_t          state_reg;
    pws_state_t          state_next;
    logic [31:0]         if_base_reg;
    logic [31:0]         dev_base_reg;
    logic [31:0]         setting_reg;
    logic [31:0]         finalize_reg;
    logic [31:0]         key_reg;
    logic [31:0]         rdata_reg;
    logic [31:0]         rdata_next;
    logic                miss_reg;
    logic                miss_next;
    logic                fwd_write_reg;
    logic [WIN_BITS-1:0] fwd_addr_reg;
    logic [31:0]         fwd_wdata_reg;

    // ******************************************
    // Decode
    // ******************************************
    wire logic            take       = req_valid && req_ready;
    wire logic [11:0]     off        = req.addr[WIN_BITS-1:0];
    wire logic            cfg_acc    = take && req.is_cfg;
    wire logic            if_hit     = take && !req.is_cfg
                                       && pws_in_window(req.addr, if_base_reg);
    wire logic            dev_win_en = ((setting_reg & SET_EN_BITS) == SET_EN_BITS);
    wire logic            dev_hit    = take && !req.is_cfg && !if_hit
                                       && pws_in_window(req.addr, dev_base_reg)
                                       && dev_win_en;
    wire logic            cfg_wr     = cfg_acc && req.write;
    wire logic            if_wr      = if_hit && req.write;
    wire logic [31:0]     bar_wval   = req.wdata & BAR_MASK;   // Low bits 0: memory, 4 KB

    assign req_ready       = (state_reg == PWS_IDLE);
    assign resp_valid      = (state_reg == PWS_RESP);
    assign resp_rdata      = rdata_reg;
    assign resp_miss       = miss_reg;
    assign cnt_req         = (state_reg == PWS_FWD);
    assign cnt_write       = fwd_write_reg;
    assign cnt_addr        = fwd_addr_reg;
    assign cnt_wdata       = fwd_wdata_reg;
    assign dev_win_enabled = dev_win_en;
    assign setup_key_ok    = (key_reg == KEY_VALUE);

    // ******************************************
    // Read data and sequencing
    // ******************************************
    always_comb begin
        state_next = state_reg;
        rdata_next = rdata_reg;
        miss_next  = miss_reg;
        case (state_reg)
            PWS_IDLE: begin
                if (take) begin
                    state_next = dev_hit ? PWS_FWD : PWS_RESP;
                    rdata_next = REG_RESET;
                    miss_next  = 1'h0;
                    if (cfg_acc) begin
                        case (off)
                            CFG_ID:       rdata_next = {DEVICE_CODE, VENDOR_CODE};
                            CFG_IF_BASE:  rdata_next = if_base_reg;
                            CFG_DEV_BASE: rdata_next = dev_base_reg;
                            default:  rdata_next = REG_RESET;
                        endcase
                    end else if (if_hit) begin
                        case (off)
                            IF_SETTING:   rdata_next = setting_reg;
                            IF_FINALIZE:  rdata_next = finalize_reg;
                            IF_SETUP_KEY: rdata_next = key_reg;
                            default:      rdata_next = REG_RESET;
                        endcase
                    end else if (!dev_hit) begin
                        miss_next = 1'h1;
                    end
                end
            end
            PWS_FWD: begin
                if (cnt_ack) begin
                    state_next = PWS_RESP;
                    rdata_next = fwd_write_reg ? REG_RESET : cnt_rdata;
                end
            end
            PWS_RESP: state_next = PWS_IDLE;
            default:  state_next = PWS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_reg <= PWS_IDLE;
            rdata_reg <= REG_RESET;
            miss_reg  <= 1'h0;
        end else begin
            state_reg <= state_next;
            rdata_reg <= rdata_next;
            miss_reg  <= miss_next;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            fwd_write_reg <= 1'h0;
            fwd_addr_reg  <= '0;
            fwd_wdata_reg <= REG_RESET;
        end else if (dev_hit) begin
            fwd_write_reg <= req.write;
            fwd_addr_reg  <= off;
            fwd_wdata_reg <= req.wdata;
        end
    end

    // ******************************************
    // Window registers
    // ******************************************
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            if_base_reg  <= REG_RESET;
            dev_base_reg <= REG_RESET;
        end else if (cfg_wr) begin
            if (off == CFG_IF_BASE)  if_base_reg  <= bar_wval;
            if (off == CFG_DEV_BASE) dev_base_reg <= bar_wval;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            setting_reg  <= REG_RESET;
            finalize_reg <= REG_RESET;
            key_reg      <= REG_RESET;
        end else if (if_wr) begin
            if (off == IF_SETTING)   setting_reg  <= req.wdata;
            if (off == IF_FINALIZE)  finalize_reg <= req.wdata;
            if (off == IF_SETUP_KEY) key_reg      <= req.wdata;
        end
    end

    // ******************************************
    // Shared trigger bus
    // ******************************************
    logic [TRIG_LINES-1:0] trig_s1_reg;
    logic [TRIG_LINES-1:0] trig_s2_reg;
    logic [TRIG_LINES-1:0] trig_s3_reg;
    logic [TRIG_LINES-1:0] trig_filt_reg;

    // Chip 0 owns a line it drives; chip 1 gets only the free lines
    wire logic [TRIG_LINES-1:0] grant1   = chip1_trig_oe & ~chip0_trig_oe;
    wire logic [TRIG_LINES-1:0] drv_oe   = chip0_trig_oe | grant1;
    wire logic [TRIG_LINES-1:0] drv_val  = (chip0_trig_oe & chip0_trig_out)
                                           | (grant1 & chip1_trig_out);
    wire logic [TRIG_LINES-1:0] in0_next = (grant1 & chip1_trig_out)
                                           | (~grant1 & trig_filt_reg);
    wire logic [TRIG_LINES-1:0] in1_next = (chip0_trig_oe & chip0_trig_out)
                                           | (~chip0_trig_oe & trig_filt_reg);
    wire logic [TRIG_LINES-1:0] agree    = ~(trig_s2_reg ^ trig_s3_reg);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            trig_s1_reg   <= '0;
            trig_s2_reg   <= '0;
            trig_s3_reg   <= '0;
            trig_filt_reg <= '0;
        end else begin
            trig_s1_reg   <= trig_pin_i;
            trig_s2_reg   <= trig_s1_reg;
            trig_s3_reg   <= trig_s2_reg;
            trig_filt_reg <= (agree & trig_s3_reg) | (~agree & trig_filt_reg);
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            trig_pin_o    <= '0;
            trig_pin_oe   <= '0;
            chip0_trig_in <= '0;
            chip1_trig_in <= '0;
            trig_conflict <= 1'h0;
        end else begin
            trig_pin_o    <= drv_val;
            trig_pin_oe   <= drv_oe;
            chip0_trig_in <= in0_next;
            chip1_trig_in <= in1_next;
            trig_conflict <= |(chip0_trig_oe & chip1_trig_oe);
        end
    end

    // ******************************************
    // Assertions
    // ******************************************
    property p_bar_read_memory;
        @(posedge sys_clk) disable iff (reset)
        (take && req.is_cfg && !req.write && (off == CFG_IF_BASE || off == CFG_DEV_BASE))
            |=> resp_valid && (resp_rdata[WIN_BITS-1:0] == '0);
    endproperty
    a_bar_read_memory: assert property (p_bar_read_memory)
        else $error("BAR reads back with low bits set");
    property p_id_read;
        @(posedge sys_clk) disable iff (reset)
        (take && req.is_cfg && !req.write && off == CFG_ID)
            |=> resp_rdata == {DEVICE_CODE, VENDOR_CODE};
    endproperty
    a_id_read: assert property (p_id_read)
        else $error("Identity codes not returned");
    property p_forward;
        @(posedge sys_clk) disable iff (reset)
        (take && !req.is_cfg && dev_win_en && pws_in_window(req.addr, dev_base_reg)
         && !pws_in_window(req.addr, if_base_reg))
            |=> cnt_req && cnt_addr == $past(off);
    endproperty
    a_forward: assert property (p_forward)
        else $error("Device window access not forwarded");
    property p_fwd_gated;
        @(posedge sys_clk) disable iff (reset)
        $rose(cnt_req) |-> $past(dev_win_en);
    endproperty
    a_fwd_gated: assert property (p_fwd_gated)
        else $error("Forward while device window disabled");
    property p_no_en_miss;
        @(posedge sys_clk) disable iff (reset)
        (take && !req.is_cfg && !dev_win_en && !pws_in_window(req.addr, if_base_reg))
            |=> resp_valid && resp_miss && !cnt_req;
    endproperty
    a_no_en_miss: assert property (p_no_en_miss)
        else $error("Disabled window access not refused");
    property p_single_driver;
        @(posedge sys_clk) disable iff (reset)
        (chip0_trig_oe[0] && chip1_trig_oe[0])
            |=> trig_conflict && trig_pin_o[0] == $past(chip0_trig_out[0]);
    endproperty
    a_single_driver: assert property (p_single_driver)
        else $error("Trigger line driven by two chips");
    property p_pass_0_to_1;
        @(posedge sys_clk) disable iff (reset)
        chip0_trig_oe[0] |=> chip1_trig_in[0] == $past(chip0_trig_out[0]);
    endproperty
    a_pass_0_to_1: assert property (p_pass_0_to_1)
        else $error("Trigger from chip 0 not passed");
    property p_key_unlock;
        @(posedge sys_clk) disable iff (reset)
        (if_wr && off == IF_SETUP_KEY && req.wdata == KEY_VALUE) |=> ##1 setup_key_ok;
    endproperty
    a_key_unlock: assert property (p_key_unlock)
        else $error("Setup key not stored");
    c_forward:  cover property (@(posedge sys_clk) disable iff (reset) cnt_req && cnt_ack);
    c_enable:   cover property (@(posedge sys_clk) disable iff (reset) $rose(dev_win_en));
    c_conflict: cover property (@(posedge sys_clk) disable iff (reset) trig_conflict);
    c_miss:     cover property (@(posedge sys_clk) disable iff (reset) resp_valid && resp_miss);
endmodule : pws_window_setup

// >>> verif/pws_cnt_model.sv
`timescale 1ns/1ps
// ****
// Counter side model
// ****
module pws_cnt_model
    import pws_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                reset,
    input  wire logic                cnt_req,
    input  wire logic                cnt_write,
    input  wire logic [WIN_BITS-1:0] cnt_addr,
    input  wire logic [31:0]         cnt_wdata,
    input  wire logic [3:0]          delay,
    output logic                     cnt_ack,
    output logic [31:0]              cnt_rdata,
    output logic [31:0]              last_wdata,
    output logic [WIN_BITS-1:0]      last_waddr
);
    logic [3:0] wait_cnt;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wait_cnt   <= 4'h0;
            cnt_ack    <= 1'h0;
            cnt_rdata  <= 32'h0;
            last_wdata <= 32'h0;
            last_waddr <= 12'h0;
        end else if (cnt_req && !cnt_ack && wait_cnt == delay) begin
            wait_cnt  <= 4'h0;
            cnt_ack   <= 1'h1;
            cnt_rdata <= 32'hc0de0000 | 32'(cnt_addr);
            if (cnt_write) begin
                last_wdata <= cnt_wdata;
                last_waddr <= cnt_addr;
            end
        end else begin
            wait_cnt  <= (cnt_req && !cnt_ack) ? wait_cnt + 4'h1 : 4'h0;
            cnt_ack   <= 1'h0;
            // Data lines are not held once the answer is gone
            cnt_rdata <= ~cnt_rdata;
        end
    end
endmodule : pws_cnt_model

// >>> verif/pws_window_setup_tb.sv
`timescale 1ns/1ps
module pws_window_setup_tb
    import pws_pkg::*;
;
    // Arbitrary identity values
    localparam logic [15:0] VEN  = 16'h0a5a;
    localparam logic [15:0] DEV  = 16'h0c3c;
    localparam logic [31:0] WVAL = (32'hffffff00 & 32'h000d1000) | 32'h0000008c;
    typedef struct packed {
        logic        c;
        logic        w;
        logic [31:0] a;
        logic [31:0] d;
        logic [31:0] rd;
        logic        ms;
    } pws_row_t;
    logic sys_clk, reset, req_valid, req_ready, resp_valid, resp_miss, cnt_req, cnt_write;
    logic cnt_ack, dev_win_enabled, setup_key_ok, trig_conflict, ms;
    pws_req_t    req;
    logic [31:0] resp_rdata, cnt_wdata, cnt_rdata, last_wdata, rd;
    logic [11:0] cnt_addr, last_waddr;
    logic [3:0]  delay;
    logic [6:0]  c0_out, c0_oe, c1_out, c1_oe, c0_in, c1_in, pin_i, pin_o, pin_oe, ext_trig;
    int          num_errors = 0;
    int          cmp_count = 0;
    pws_row_t    rows [0:16] = '{
        '{1'h1, 1'h0, 32'h0, 32'h0, {DEV, VEN}, 1'h0},
        '{1'h1, 1'h1, 32'h10, 32'h000d0123, 32'h0, 1'h0},
        '{1'h1, 1'h0, 32'h10, 32'h0, 32'h000d0000, 1'h0},
        '{1'h0, 1'h1, 32'h000d0340, 32'h0000aeae, 32'h0, 1'h0},
        '{1'h1, 1'h1, 32'h14, 32'h000d1000, 32'h0, 1'h0},
        '{1'h1, 1'h0, 32'h14, 32'h0, 32'h000d1000, 1'h0},
        '{1'h0, 1'h0, 32'h000d1010, 32'h0, 32'h0, 1'h1},
        '{1'h0, 1'h1, 32'h000d00c4, WVAL, 32'h0, 1'h0},
        '{1'h0, 1'h1, 32'h000d00f4, 32'h0, 32'h0, 1'h0},
        '{1'h0, 1'h0, 32'h000d00c4, 32'h0, WVAL, 1'h0},
        '{1'h0, 1'h0, 32'h000d1010, 32'h0, 32'hc0de0010, 1'h0},
        '{1'h0, 1'h0, 32'h000d1ffc, 32'h0, 32'hc0de0ffc, 1'h0},
        '{1'h0, 1'h0, 32'h000d2000, 32'h0, 32'h0, 1'h1},
        '{1'h0, 1'h1, 32'h000d1020, 32'h12345678, 32'h0, 1'h0},
        '{1'h0, 1'h0, 32'h000d0340, 32'h0, 32'h0000aeae, 1'h0},
        '{1'h1, 1'h0, 32'h20, 32'h0, 32'h0, 1'h0},
        '{1'h0, 1'h0, 32'h000d0ffc, 32'h0, 32'h0, 1'h0}};

    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_trig);

    pws_window_setup #(.VENDOR_CODE(VEN), .DEVICE_CODE(DEV), .TRIG_LINES(7)) u_dut (
        .sys_clk(sys_clk), .reset(reset), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
        .resp_miss(resp_miss), .cnt_req(cnt_req), .cnt_write(cnt_write),
        .cnt_addr(cnt_addr), .cnt_wdata(cnt_wdata), .cnt_ack(cnt_ack),
        .cnt_rdata(cnt_rdata), .dev_win_enabled(dev_win_enabled),
        .setup_key_ok(setup_key_ok), .chip0_trig_out(c0_out), .chip0_trig_oe(c0_oe),
        .chip1_trig_out(c1_out), .chip1_trig_oe(c1_oe), .chip0_trig_in(c0_in),
        .chip1_trig_in(c1_in), .trig_pin_i(pin_i), .trig_pin_o(pin_o),
        .trig_pin_oe(pin_oe), .trig_conflict(trig_conflict));

    pws_cnt_model u_cnt (
        .sys_clk(sys_clk), .reset(reset), .cnt_req(cnt_req), .cnt_write(cnt_write),
        .cnt_addr(cnt_addr), .cnt_wdata(cnt_wdata), .delay(delay), .cnt_ack(cnt_ack),
        .cnt_rdata(cnt_rdata), .last_wdata(last_wdata), .last_waddr(last_waddr));

    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ****
    // Checking and host tasks
    // ****
    task automatic results();
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic tick(inout int n);
        @(negedge sys_clk);
        n++;
        if (n > 60) begin
            num_errors++;
            results();
        end
    endtask : tick

    task automatic host(input logic c, input logic w, input logic [31:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        req_valid <= 1'h1;
        req       <= '{c, w, a, d};
        do tick(n); while (req_ready !== 1'h1);
        @(posedge sys_clk);
        req_valid <= 1'h0;
        do tick(n); while (resp_valid !== 1'h1);
        rd = resp_rdata;
        ms = resp_miss;
    endtask : host

    initial begin
        reset <= 1'h1;
        req_valid <= 1'h0;
        req <= '0;
        {c0_out, c0_oe, c1_out, c1_oe, ext_trig} <= '0;
        delay <= 4'h0;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("ready_rst", 32'(req_ready), 32'h1);
        chk("en_rst", 32'(dev_win_enabled), 32'h0);
        chk("pin_oe_rst", 32'(pin_oe), 32'h0);
        @(posedge sys_clk);
        reset <= 1'h0;
        for (int i = 0; i < 17; i++) begin
            delay <= 4'(i % 4);
            host(rows[i].c, rows[i].w, rows[i].a, rows[i].d);
            chk($sformatf("rdata%0d", i), rd, rows[i].rd);
            chk($sformatf("miss%0d", i), 32'(ms), 32'(rows[i].ms));
        end
        chk("fwd_addr", 32'(last_waddr), 32'h020);
        chk("fwd_data", last_wdata, 32'h12345678);
        chk("key_ok", 32'(setup_key_ok), 32'h1);
        chk("win_en", 32'(dev_win_enabled), 32'h1);
        host(1'h0, 1'h1, 32'h000d00c4, 32'h000d1088);
        chk("win_part", 32'(dev_win_enabled), 32'h0);
        host(1'h0, 1'h0, 32'h000d1010, 32'h0);
        chk("part_miss", 32'(ms), 32'h1);
        // ****
        // Shared trigger lines
        // ****
        @(posedge sys_clk);
        {c0_oe, c0_out, c1_oe, c1_out} <= {7'h01, 7'h01, 7'h01, 7'h00};
        repeat (2) @(negedge sys_clk);
        chk("pin_oe", 32'(pin_oe), 32'h01);
        chk("pin_o", 32'(pin_o), 32'h01);
        chk("conflict", 32'(trig_conflict), 32'h1);
        chk("c1_in", 32'(c1_in[0]), 32'h1);
        @(posedge sys_clk);
        {c0_oe, c1_out} <= {7'h00, 7'h01};
        repeat (2) @(negedge sys_clk);
        chk("c1_pin", 32'(pin_o & pin_oe), 32'h01);
        chk("no_conf", 32'(trig_conflict), 32'h0);
        @(posedge sys_clk);
        {c1_oe, ext_trig} <= {7'h00, 7'h08};
        repeat (8) @(negedge sys_clk);
        chk("pin_in", 32'({c0_in[3], c1_in[3]}), 32'h3);
        @(posedge sys_clk);
        reset <= 1'h1;
        @(posedge sys_clk);
        reset <= 1'h0;
        host(1'h1, 1'h0, 32'h14, 32'h0);
        chk("dev_base_rst", rd, 32'h0);
        chk("en_rst2", 32'({dev_win_enabled, setup_key_ok}), 32'h0);
        results();
    end
endmodule : pws_window_setup_tb
